/* rrsa_addr.sv */
// File register address former: access bank, banked and indexed offset.
`timescale 1ns/1ps
module rrsa_addr (
  // Instruction fields
  input wire logic [7:0] f_i,
  input wire logic a_i,
  // Core state
  input wire logic [3:0] bank_select_reg_i,
  input wire logic [11:0] index_base_i,
  input wire logic ext_set_i,
  // Result
  output logic [11:0] addr_o,
  output logic indexed_o
);
  wire idx_w = ext_set_i && !a_i && (f_i <= rrsa_pkg::RRSA_IDX_LIMIT); // RULE_04
  wire [11:0] acc_w = (f_i < rrsa_pkg::RRSA_ACC_SPLIT) ? {4'h0, f_i}
      : {rrsa_pkg::RRSA_ACC_HI_BANK, f_i}; // RULE_02
  wire [11:0] bank_w = {bank_select_reg_i, f_i}; // RULE_03
  wire [11:0] idx_addr_w = 12'(index_base_i + {4'h0, f_i}); // RULE_04

  assign indexed_o = idx_w;
  assign addr_o = idx_w ? idx_addr_w : (a_i ? bank_w : acc_w);
endmodule

/* rrsa_exec.sv */
// Execution slice for rotate-right-no-carry and set-all-ones instructions.
`timescale 1ns/1ps
// Behaviour
// RULE_01 - Set-all-ones writes FFh into the addressed file register.
// RULE_02 - Bank-access bit 0 selects the fixed access bank, bank select ignored.
// RULE_03 - Bank-access bit 1 uses the bank select register to choose the bank.
// RULE_04 - Extended set, bank bit 0, address up to 5Fh: indexed literal offset.
// RULE_05 - Rotate moves contents right one place, bit 0 into bit 7, carry kept.
// RULE_06 - Rotate with destination bit 0 writes working register, file unchanged.
// RULE_07 - Set-all-ones keeps flags, one cycle, writes in the fourth quarter.
module rrsa_exec (
  // Clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // Instruction issue, one per instruction cycle, sampled in the first quarter
  input wire logic instr_valid_i,
  input wire logic [15:0] instr_i,
  // Core state
  input wire logic [3:0] bank_select_reg_i,
  input wire logic [11:0] index_base_i,
  input wire logic ext_set_i,
  input wire logic carry_i,
  // File register read port
  output logic [11:0] rd_addr_o,
  input wire logic [7:0] rd_data_i,
  // Write-back
  output rrsa_pkg::rrsa_wr_t wr_o,
  output logic carry_o,
  output logic flag_n_o,
  output logic flag_z_o,
  output logic flags_we_o,
  output rrsa_pkg::rrsa_phase_t phase_o,
  output logic busy_o
);

  // ----------------------------------------------------------------
  // Quarter phase sequencer
  // ----------------------------------------------------------------
  // The sequencer runs free from reset, so an instruction issued late waits for the next Q1.
  rrsa_pkg::rrsa_phase_t ph_q, ph_d;

  always_comb begin
    unique case (ph_q)
      rrsa_pkg::RRSA_Q1: ph_d = rrsa_pkg::RRSA_Q2;
      rrsa_pkg::RRSA_Q2: ph_d = rrsa_pkg::RRSA_Q3;
      rrsa_pkg::RRSA_Q3: ph_d = rrsa_pkg::RRSA_Q4;
      rrsa_pkg::RRSA_Q4: ph_d = rrsa_pkg::RRSA_Q1;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ph_q <= rrsa_pkg::RRSA_Q1;
    end else begin
      ph_q <= ph_d;
    end
  end

  assign phase_o = ph_q;

  // ----------------------------------------------------------------
  // Decode, captured in Q1
  // ----------------------------------------------------------------
  // Only the edge that ends Q1 takes an instruction; instr_i is ignored elsewhere.
  localparam int RRSA_TOP = rrsa_pkg::RRSA_OPC_HI;
  wire is_rot_w = instr_valid_i
      && (instr_i[RRSA_TOP:10] == rrsa_pkg::RRSA_OPC_ROT_NC);
  wire is_set_w = instr_valid_i
      && (instr_i[RRSA_TOP:9] == rrsa_pkg::RRSA_OPC_SET_ONES);
  wire q1_w = (ph_q == rrsa_pkg::RRSA_Q1);

  logic rot_q, set_q, dst_q;
  logic [11:0] addr_q;
  logic [11:0] addr_w;

  rrsa_addr rrsa_addr_i (
    .f_i(instr_i[7:0]),
    .a_i(instr_i[rrsa_pkg::RRSA_A_BIT]),
    .bank_select_reg_i(bank_select_reg_i),
    .index_base_i(index_base_i),
    .ext_set_i(ext_set_i),
    .addr_o(addr_w),
    .indexed_o()
  );

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rot_q <= 1'b0;
      set_q <= 1'b0;
      dst_q <= 1'b0;
      addr_q <= 12'h000;
    end else if (q1_w) begin
      rot_q <= is_rot_w;
      set_q <= is_set_w;
      dst_q <= instr_i[rrsa_pkg::RRSA_D_BIT];
      addr_q <= addr_w;
    end
  end

  assign rd_addr_o = addr_q;
  assign busy_o = rot_q | set_q;

  // ----------------------------------------------------------------
  // Read in Q2, process in Q3
  // ----------------------------------------------------------------
  // The rotation works on the Q2 capture, so rd_data_i may change after Q2.
  logic [7:0] src_q;
  wire q2_w = (ph_q == rrsa_pkg::RRSA_Q2);
  wire q3_w = (ph_q == rrsa_pkg::RRSA_Q3);
  wire [7:0] rot_w = {src_q[0], src_q[7:1]}; // RULE_05
  wire [7:0] res_w = set_q ? rrsa_pkg::RRSA_ALL_ONES : rot_w; // RULE_01

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      src_q <= rrsa_pkg::RRSA_RESET_BYTE;
    end else if (q2_w) begin
      src_q <= rd_data_i;
    end
  end

  // ----------------------------------------------------------------
  // Write to destination in Q4
  // ----------------------------------------------------------------
  wire q4_w = (ph_q == rrsa_pkg::RRSA_Q4);
  // Write-back and flags are registered on the edge that ends Q3 and stand for all of Q4.
  wire wr_go_w = q3_w && (rot_q || set_q); // RULE_07
  wire to_file_w = set_q || dst_q; // RULE_06
  wire fl_we_w = q3_w && rot_q; // RULE_07
  rrsa_pkg::rrsa_wr_t wr_d, wr_q;
  logic fl_we_q, fl_n_q, fl_z_q;

  assign wr_d = '{en: wr_go_w, to_file: wr_go_w && to_file_w, addr: addr_q, data: res_w};

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      wr_q <= '0;
      fl_we_q <= 1'b0;
      fl_n_q <= 1'b0;
      fl_z_q <= 1'b0;
    end else begin
      wr_q <= wr_d;
      fl_we_q <= fl_we_w;
      fl_n_q <= rot_w[7]; // RULE_05
      fl_z_q <= (rot_w == 8'h00); // RULE_05
    end
  end

  assign wr_o = wr_q;
  assign flags_we_o = fl_we_q;
  assign flag_n_o = fl_n_q;
  assign flag_z_o = fl_z_q;
  assign carry_o = carry_i; // RULE_05

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Most checks look at the registered outputs one edge after the cause; carry_keep_a and wr_phase_a check the same cycle, other_op_a three edges on.
  set_ones_a: assert property (@(posedge clock_i) disable iff (srst_i) // RULE_01
      q3_w && set_q |=> wr_o.en && wr_o.to_file && wr_o.data == rrsa_pkg::RRSA_ALL_ONES)
    else $error("set-all-ones did not write FFh");
  acc_bank_a: assert property (@(posedge clock_i) disable iff (srst_i) // RULE_02
      q1_w && !instr_i[rrsa_pkg::RRSA_A_BIT]
      && !(ext_set_i && instr_i[7:0] <= rrsa_pkg::RRSA_IDX_LIMIT)
      |=> addr_q[11:8] == (addr_q[7] ? rrsa_pkg::RRSA_ACC_HI_BANK : 4'h0)
      && addr_q[7:0] == $past(instr_i[7:0]))
    else $error("access bank address wrong");
  bank_sel_a: assert property (@(posedge clock_i) disable iff (srst_i) // RULE_03
      q1_w && instr_i[rrsa_pkg::RRSA_A_BIT]
      |=> addr_q == {$past(bank_select_reg_i), $past(instr_i[7:0])})
    else $error("banked address ignores bank select");
  idx_mode_a: assert property (@(posedge clock_i) disable iff (srst_i) // RULE_04
      q1_w && ext_set_i && !instr_i[rrsa_pkg::RRSA_A_BIT]
      && instr_i[7:0] <= rrsa_pkg::RRSA_IDX_LIMIT
      |=> addr_q == 12'($past(index_base_i) + {4'h0, $past(instr_i[7:0])}))
    else $error("indexed offset address wrong");
  rot_data_a: assert property (@(posedge clock_i) disable iff (srst_i) // RULE_05
      q2_w && rot_q ##1 q3_w |=> $past(rd_data_i, 2) == {wr_o.data[6:0], wr_o.data[7]})
    else $error("rotate result wrong");
  rot_wreg_a: assert property (@(posedge clock_i) disable iff (srst_i) // RULE_06
      q3_w && rot_q && !dst_q |=> wr_o.en && !wr_o.to_file)
    else $error("rotate to working register touched the file");
  set_flags_a: assert property (@(posedge clock_i) disable iff (srst_i) // RULE_07
      q3_w && set_q |=> !flags_we_o)
    else $error("set-all-ones changed flags");
  wr_phase_a: assert property (@(posedge clock_i) disable iff (srst_i) // RULE_07
      wr_o.en |-> q4_w && $past(ph_q, 3) == rrsa_pkg::RRSA_Q1)
    else $error("write outside fourth quarter");
  carry_keep_a: assert property (@(posedge clock_i) disable iff (srst_i) // RULE_05
      rot_q |-> carry_o == carry_i)
    else $error("carry disturbed");

  flags_rot_a: assert property (@(posedge clock_i) disable iff (srst_i) // RULE_05
      q3_w && rot_q |=> flags_we_o && flag_n_o == wr_o.data[7] && flag_z_o == (wr_o.data == 8'h00))
    else $error("rotate flags wrong");
  wr_addr_a: assert property (@(posedge clock_i) disable iff (srst_i) // RULE_01
      q3_w && (rot_q || set_q) |=> wr_o.addr == $past(rd_addr_o))
    else $error("write address differs from read address");
  phase_step_a: assert property (@(posedge clock_i) disable iff (srst_i) // RULE_07
      ph_q == rrsa_pkg::RRSA_Q1 |=> ph_q == rrsa_pkg::RRSA_Q2)
    else $error("quarter phase did not advance");
  other_op_a: assert property (@(posedge clock_i) disable iff (srst_i) // RULE_07
      q1_w && !(is_rot_w || is_set_w) |-> ##3 !wr_o.en)
    else $error("write without an accepted instruction");
  busy_hold_a: assert property (@(posedge clock_i) disable iff (srst_i) // RULE_07
      q1_w && (is_rot_w || is_set_w) |=> busy_o [*4])
    else $error("busy dropped inside the instruction cycle");
  late_issue_a: assert property (@(posedge clock_i) disable iff (srst_i) // RULE_07
      !q1_w |=> $stable(rot_q) && $stable(set_q))
    else $error("instruction taken outside the first quarter");
  rd_addr_hold_a: assert property (@(posedge clock_i) disable iff (srst_i) // RULE_02
      !q1_w |=> $stable(rd_addr_o))
    else $error("read address moved inside the instruction cycle");
  rst_clear_a: assert property (@(posedge clock_i) // RULE_07
      srst_i |=> !wr_o.en && !busy_o && ph_q == rrsa_pkg::RRSA_Q1)
    else $error("reset did not clear the slice");

  set_run_c: cover property (@(posedge clock_i) disable iff (srst_i)
      q3_w && set_q ##1 wr_o.en);
  rot_file_c: cover property (@(posedge clock_i) disable iff (srst_i)
      q3_w && rot_q && dst_q);
  rot_w_c: cover property (@(posedge clock_i) disable iff (srst_i)
      q3_w && rot_q && !dst_q);
  idx_c: cover property (@(posedge clock_i) disable iff (srst_i)
      q1_w && ext_set_i && !instr_i[8] && instr_i[7:0] <= 8'h5F && instr_valid_i);
  reset_mid_c: cover property (@(posedge clock_i) busy_o && srst_i);

endmodule

/* rrsa_exec_test.sv */
// Self-checking testbench for the rotate-right and set-all-ones execution slice.
`timescale 1ns/1ps
module rrsa_exec_test;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  logic instr_valid_i = 1'b0;
  logic [15:0] instr_i = 16'h0000;
  logic [3:0] bank_select_reg_i = 4'h0;
  logic [11:0] index_base_i = 12'h000;
  logic ext_set_i = 1'b0;
  logic carry_i = 1'b0;
  logic [7:0] rd_data_i = 8'h00;
  logic [11:0] rd_addr_o;
  rrsa_pkg::rrsa_wr_t wr_o;
  logic carry_o;
  logic flag_n_o;
  logic flag_z_o;
  logic flags_we_o;
  rrsa_pkg::rrsa_phase_t phase_o;
  logic busy_o;
  int failures = 0;
  int checks = 0;

  always #2 clock_i = ~clock_i;

  rrsa_exec rrsa_exec_i (
    .clock_i(clock_i), .srst_i(srst_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
    .bank_select_reg_i(bank_select_reg_i), .index_base_i(index_base_i),
    .ext_set_i(ext_set_i), .carry_i(carry_i), .rd_addr_o(rd_addr_o), .rd_data_i(rd_data_i),
    .wr_o(wr_o), .carry_o(carry_o), .flag_n_o(flag_n_o), .flag_z_o(flag_z_o),
    .flags_we_o(flags_we_o), .phase_o(phase_o), .busy_o(busy_o)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic cmp(input string nm, input logic [11:0] e, input logic [11:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic step;
    @(posedge clock_i);
    #1;
  endtask

  // Issues one instruction in the Q1 slot and follows it to the next Q1.
  task automatic do_op(input logic [15:0] ins, input logic [7:0] rdat, input logic [11:0] ea,
                       input logic ef, input logic [7:0] ed, input logic efw);
    instr_i = ins;
    instr_valid_i = 1'b1;
    carry_i = ~carry_i;
    step;
    instr_valid_i = 1'b0;
    instr_i = 16'hFFFF;
    rd_data_i = rdat;
    cmp("rd_addr", ea, rd_addr_o);
    cmp("busy", 12'h001, busy_o);
    step;
    cmp("wr_en_q3", 12'h000, wr_o.en);
    step;
    rd_data_i = ~rdat;
    cmp("wr_en_q4", 12'h001, wr_o.en);
    cmp("to_file", ef, wr_o.to_file);
    cmp("wr_data", ed, wr_o.data);
    if (ef) cmp("wr_addr", ea, wr_o.addr);
    cmp("flags_we", efw, flags_we_o);
    if (efw) cmp("flag_n", ed[7], flag_n_o);
    if (efw) cmp("flag_z", ed == 8'h00, flag_z_o);
    cmp("carry", carry_i, carry_o);
    step;
    cmp("wr_en_q1", 12'h000, wr_o.en);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_rotate;
    bank_select_reg_i = 4'h7;
    do_op({6'h10, 1'b1, 1'b0, 8'h25}, 8'hD7, 12'h025, 1'b1, 8'hEB, 1'b1);
    do_op({6'h10, 1'b0, 1'b1, 8'h90}, 8'h01, 12'h790, 1'b0, 8'h80, 1'b1);
    do_op({6'h10, 1'b1, 1'b0, 8'hC4}, 8'h00, 12'hFC4, 1'b1, 8'h00, 1'b1);
    $display("test_rotate done");
  endtask

  task automatic test_set;
    bank_select_reg_i = 4'h5;
    do_op({7'h34, 1'b1, 8'h12}, 8'h5A, 12'h512, 1'b1, 8'hFF, 1'b0);
    do_op({7'h34, 1'b0, 8'hA0}, 8'h00, 12'hFA0, 1'b1, 8'hFF, 1'b0);
    $display("test_set done");
  endtask

  task automatic test_indexed;
    ext_set_i = 1'b1;
    bank_select_reg_i = 4'h2;
    index_base_i = 12'h3C0;
    do_op({7'h34, 1'b0, 8'h5F}, 8'h11, 12'h41F, 1'b1, 8'hFF, 1'b0);
    do_op({6'h10, 1'b1, 1'b0, 8'h60}, 8'h02, 12'h060, 1'b1, 8'h01, 1'b1);
    do_op({6'h10, 1'b1, 1'b1, 8'h10}, 8'h80, 12'h210, 1'b1, 8'h40, 1'b1);
    ext_set_i = 1'b0;
    $display("test_indexed done");
  endtask

  task automatic test_refused;
    instr_i = 16'h6A55;
    instr_valid_i = 1'b1;
    repeat (8) begin
      step;
      cmp("wr_en_other", 12'h000, wr_o.en);
      cmp("busy_other", 12'h000, busy_o);
    end
    instr_valid_i = 1'b0;
    $display("test_refused done");
  endtask

  // Holds a valid rotate only outside Q1 and checks that it is never taken.
  task automatic test_late;
    step;
    instr_i = {6'h10, 1'b1, 1'b0, 8'h25};
    instr_valid_i = 1'b1;
    repeat (3) step;
    instr_valid_i = 1'b0;
    instr_i = 16'hFFFF;
    repeat (4) begin
      step;
      cmp("wr_en_late", 12'h000, wr_o.en);
      cmp("busy_late", 12'h000, busy_o);
    end
    $display("test_late done");
  endtask

  // Resets in the middle of a rotate, checks that nothing is written, then runs one op.
  task automatic test_reset_mid;
    bank_select_reg_i = 4'h5;
    instr_i = {6'h10, 1'b1, 1'b0, 8'h33};
    instr_valid_i = 1'b1;
    step;
    instr_valid_i = 1'b0;
    instr_i = 16'hFFFF;
    step;
    srst_i = 1'b1;
    repeat (2) begin
      step;
      cmp("wr_en_reset", 12'h000, wr_o.en);
    end
    srst_i = 1'b0;
    cmp("phase_mid_reset", rrsa_pkg::RRSA_Q1, phase_o);
    cmp("busy_mid_reset", 12'h000, busy_o);
    do_op({7'h34, 1'b1, 8'h33}, 8'h00, 12'h533, 1'b1, 8'hFF, 1'b0);
    $display("test_reset_mid done");
  endtask

  task automatic end_of_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clock_i);
    #1;
    srst_i = 1'b0;
    cmp("phase_reset", rrsa_pkg::RRSA_Q1, phase_o);
    cmp("busy_reset", 12'h000, busy_o);
    test_rotate();
    test_set();
    test_indexed();
    test_refused();
    test_late();
    test_reset_mid();
    end_of_test();
  end

  initial begin
    #4000;
    failures++;
    end_of_test();
  end
endmodule

/* rrsa_pkg.sv */
// Package for the rotate-right and set-all-ones execution slice.
package rrsa_pkg;

  // ----------------------------------------------------------------
  // Encodings and constants
  // ----------------------------------------------------------------
  localparam logic [5:0] RRSA_OPC_ROT_NC = 6'h10;
  localparam logic [6:0] RRSA_OPC_SET_ONES = 7'h34;
  localparam logic [7:0] RRSA_ALL_ONES = 8'hFF;
  localparam logic [7:0] RRSA_IDX_LIMIT = 8'h5F;
  localparam logic [7:0] RRSA_ACC_SPLIT = 8'h80;
  localparam logic [3:0] RRSA_ACC_HI_BANK = 4'hF;
  localparam logic [7:0] RRSA_RESET_BYTE = 8'h00;
  localparam int RRSA_OPC_HI = 15;
  localparam int RRSA_D_BIT = 9;
  localparam int RRSA_A_BIT = 8;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RRSA_Q1 = 2'b00,
    RRSA_Q2 = 2'b01,
    RRSA_Q3 = 2'b11,
    RRSA_Q4 = 2'b10
  } rrsa_phase_t;

  typedef struct packed {
    logic en;
    logic to_file;
    logic [11:0] addr;
    logic [7:0] data;
  } rrsa_wr_t;

endpackage
